// [core/vis_dac_latch.sv]
`timescale 1ns/100ps
module vis_dac_latch
  import vis_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Synchronised DAC input side
  input wire logic latch_rise,
  input wire logic first_marker,
  input wire logic [9:0] dac_data,
  // DAC words
  output logic [DAC_N*VID_W-1:0] dac_words
);

  logic [1:0] ptr;
  wire [1:0] slot = first_marker ? 2'h0 : ptr;

  // shared bus latched word by word
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ptr <= 2'h0;
      dac_words <= '0;
    end
    else if (latch_rise)
    begin
      dac_words[slot*VID_W +: VID_W] <= dac_data;
      ptr <= slot + 2'h1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_dac0_load;
    latch_rise && first_marker |=> dac_words[VID_W-1:0] == $past(dac_data);
  endproperty
  a_dac0_load: assert property (p_dac0_load) else $error("DAC0 word not loaded");

  property p_dac_next;
    latch_rise && !first_marker && ptr == 2'h1 |=> dac_words[2*VID_W-1:VID_W] == $past(dac_data);
  endproperty
  a_dac_next: assert property (p_dac_next) else $error("DAC1 word not loaded");

endmodule

// [core/vis_pkg.sv]
package vis_pkg;

  // Selection codes
  localparam logic [3:0] SEL_CVBS_IN1 = 4'h0;
  localparam logic [3:0] SEL_CVBS_IN2 = 4'h1;
  localparam logic [3:0] SEL_CVBS_IN3 = 4'h2;
  localparam logic [3:0] SEL_RESERVED = 4'h3;
  localparam logic [3:0] SEL_CVBS_IN5 = 4'h4;
  localparam logic [3:0] SEL_CVBS_IN6 = 4'h5;
  localparam logic [3:0] SEL_YC_IN1_IN4 = 4'h6;
  localparam logic [3:0] SEL_YC_IN2_IN3 = 4'h7;
  localparam logic [3:0] SEL_YUV = 4'h8;
  localparam logic [3:0] SEL_AUX_IN1 = 4'h9;
  localparam logic [3:0] SEL_AUX_IN2 = 4'ha;
  localparam logic [3:0] SEL_RESET = SEL_CVBS_IN1;

  // Widths
  localparam int SEL_W = 4;
  localparam int AIN_N = 6;
  localparam int SHA_N = 3;
  localparam int ADC_W = 12;
  localparam int HEADROOM_W = 2;
  localparam int VID_W = 10;
  localparam int DAC_N = 4;
  localparam int OVL_N = 3;
  localparam int AUX_N = 8;

  // SHA indices
  localparam logic [1:0] SHA_0 = 2'h0;
  localparam logic [1:0] SHA_1 = 2'h1;
  localparam logic [1:0] SHA_2 = 2'h2;

  // Timing
  localparam int CLK_KHZ = 125000;
  localparam int VID_RATE_KHZ = 54000;
  localparam int AUX_RATE_KHZ = 843;
  // Highest rate means least spacing: round cycles up
  localparam int VID_DIV = (CLK_KHZ + VID_RATE_KHZ - 1) / VID_RATE_KHZ;
  localparam int AUX_DIV = (CLK_KHZ + AUX_RATE_KHZ - 1) / AUX_RATE_KHZ;

  typedef enum logic [1:0] {
    FMT_CVBS = 2'b00,
    FMT_YC = 2'b01,
    FMT_YUV = 2'b10,
    FMT_AUX = 2'b11
  } vis_fmt_t;

  function automatic logic vis_code_ok(input logic [3:0] code);
    vis_code_ok = (code <= SEL_AUX_IN2) && (code != SEL_RESERVED);
  endfunction

endpackage

// [core/vis_route_dec.sv]
`timescale 1ns/100ps
module vis_route_dec
  import vis_pkg::*;
(
  vis_route_if.dec rt
);

  wire [3:0] c = rt.code;
  wire is_aux = (c == SEL_AUX_IN1) || (c == SEL_AUX_IN2);
  wire is_yc = (c == SEL_YC_IN1_IN4) || (c == SEL_YC_IN2_IN3);
  wire is_yuv = (c == SEL_YUV);

  assign rt.aux_mode = is_aux;
  assign rt.fmt = is_yuv ? FMT_YUV : is_yc ? FMT_YC : is_aux ? FMT_AUX : FMT_CVBS;

  assign rt.composite_sel = (c == SEL_CVBS_IN1 || c == SEL_AUX_IN1) ? 6'h01 :
                            (c == SEL_CVBS_IN2 || c == SEL_AUX_IN2) ? 6'h02 :
                            (c == SEL_CVBS_IN3) ? 6'h04 :
                            (c == SEL_CVBS_IN5) ? 6'h10 :
                            (c == SEL_CVBS_IN6) ? 6'h20 : 6'h00;
  assign rt.luma_sel = (c == SEL_YC_IN1_IN4) ? 6'h01 :
                       (c == SEL_YC_IN2_IN3 || is_yuv) ? 6'h02 : 6'h00;
  // first difference shares the chroma path
  assign rt.chroma_sel = (c == SEL_YC_IN1_IN4) ? 6'h08 :
                         (c == SEL_YC_IN2_IN3 || is_yuv) ? 6'h04 : 6'h00;
  assign rt.cdiff2_sel = is_yuv ? 6'h20 : 6'h00;
  // aux inputs three to six single ended
  assign rt.single_ended = is_aux ? 6'h3c : 6'h00;

  assign rt.sha_used = is_yuv ? 3'h7 : is_yc ? 3'h3 :
                       (c == SEL_CVBS_IN3) ? 3'h2 :
                       (c == SEL_CVBS_IN6) ? 3'h4 : 3'h1;
  assign rt.sha_primary = (c == SEL_CVBS_IN3) ? SHA_1 :
                          (c == SEL_CVBS_IN6) ? SHA_2 : SHA_0;

endmodule

// [core/vis_route_if.sv]
`timescale 1ns/100ps
interface vis_route_if;
  import vis_pkg::*;
  logic [3:0] code;
  vis_fmt_t fmt;
  logic [5:0] composite_sel;
  logic [5:0] luma_sel;
  logic [5:0] chroma_sel;
  logic [5:0] cdiff2_sel;
  logic [5:0] single_ended;
  logic [2:0] sha_used;
  logic [1:0] sha_primary;
  logic aux_mode;

  modport dec (input code, output fmt, composite_sel, luma_sel, chroma_sel,
    cdiff2_sel, single_ended, sha_used, sha_primary, aux_mode);
  modport use_side (output code, input fmt, composite_sel, luma_sel, chroma_sel,
    cdiff2_sel, single_ended, sha_used, sha_primary, aux_mode);
endinterface

// [core/vis_top.sv]
// Notes on behaviour
// - A 4-bit selection code chooses inputs and video format.
// - Codes 0,1,2,4,5 route composite from input 1,2,3,5,6; 3 reserved.
// - Code 6: luma in1, chroma in4; code 7: luma in2, chroma in3.
// - Code 8: component, luma in2, differences in3 and in6, three SHAs.
// - Codes 9 and 10: composite in1 or in2, inputs 3-6 as 8 aux.
// - Aux inputs single-ended against reference, all others differential.
// - Eight aux channels sampled by a separate converter at 843 kHz.
// - Samples are 12 bits, two bits kept as gain/offset headroom.
// - Video conversion rate at most 54 MHz.
// - Sync high exactly on red-difference or chroma output samples, except one sent in the cycle the code changes.
// - Three overlay inputs multiplex onto the DAC outputs.
// - One shared 10-bit data bus feeds all four DACs via two clocks.
// - Overlay passes only while overlay enable is held high.
// - Each video sample is presented on the output bus at a clock edge.
`timescale 1ns/100ps
module vis_top
  import vis_pkg::*;
#(
  parameter int AUX_CYCLES = AUX_DIV
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Selection code from the management port
  input wire logic [3:0] input_select,
  // Converter samples, one word per SHA
  input wire logic [SHA_N*ADC_W-1:0] sha_samples,
  // Overlay and DAC pins
  input wire logic overlay_enable,
  input wire logic [2:0] overlay_in,
  input wire logic [1:0] dac_in_clocks,
  input wire logic [9:0] dac_data,
  // Routing outputs
  output logic [3:0] active_select,
  output logic select_reserved,
  output logic [5:0] composite_route,
  output logic [5:0] luma_route,
  output logic [5:0] chroma_route,
  output logic [5:0] cdiff2_route,
  output logic [5:0] single_ended,
  output logic [2:0] sha_enable,
  output logic aux_mode,
  // Aux converter control
  output logic aux_strobe,
  output logic [2:0] aux_channel,
  // Video output
  output logic [9:0] video_out,
  output logic video_strobe,
  output logic sync_out,
  // DAC side
  output logic [DAC_N*VID_W-1:0] dac_words,
  output logic [2:0] overlay_route,
  output logic [2:0] overlay_level
);

  // Counter widths and the spacing check assume this range
  if (AUX_CYCLES < 4 || AUX_CYCLES > 4096)
    $error("AUX_CYCLES out of range");

  // Pin synchronisers: code, enable, overlay, dac clocks, dac data
  localparam int SYN_W = SEL_W + 1 + OVL_N + 2 + VID_W;
  wire [SYN_W-1:0] pins = {input_select, overlay_enable, overlay_in, dac_in_clocks, dac_data};
  logic [SYN_W-1:0] syn_a;
  logic [SYN_W-1:0] syn_b;

  genvar gi;
  generate
    for (gi = 0; gi < SYN_W; gi++)
    begin : g_sync
      always_ff @(posedge mclk or negedge resetn)
      begin
        if (!resetn)
        begin
          syn_a[gi] <= 1'b0;
          syn_b[gi] <= 1'b0;
        end
        else
        begin
          syn_a[gi] <= pins[gi];
          syn_b[gi] <= syn_a[gi];
        end
      end
    end
  endgenerate

  wire [3:0] sel_s = syn_b[SYN_W-1 -: SEL_W];
  wire ovl_en_s = syn_b[VID_W + 2 + OVL_N];
  wire [2:0] ovl_s = syn_b[VID_W + 2 +: OVL_N];
  wire [1:0] dclk_s = syn_b[VID_W +: 2];
  wire [9:0] ddata_s = syn_b[VID_W-1:0];

  // selection code held, illegal codes ignored
  logic [3:0] cur_code;
  wire sel_legal = vis_code_ok(sel_s);
  wire code_load = sel_legal && (sel_s != cur_code);

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      cur_code <= SEL_RESET;
    else if (code_load)
      cur_code <= sel_s;
  end

  assign active_select = cur_code;
  assign select_reserved = !sel_legal;

  vis_route_if rt ();
  assign rt.code = cur_code;

  vis_route_dec u_dec (
    .rt(rt)
  );

  assign composite_route = rt.composite_sel;
  assign luma_route = rt.luma_sel;
  assign chroma_route = rt.chroma_sel;
  assign cdiff2_route = rt.cdiff2_sel;
  assign single_ended = rt.single_ended;
  assign sha_enable = rt.sha_used;
  assign aux_mode = rt.aux_mode;

  // video tick no faster than 54 MHz
  localparam int VID_CW = $clog2(VID_DIV + 1);
  logic [VID_CW-1:0] vid_cnt;
  wire vid_tick = (vid_cnt == VID_CW'(VID_DIV - 1));

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      vid_cnt <= '0;
    else
      vid_cnt <= vid_tick ? '0 : vid_cnt + VID_CW'(1);
  end

  // aux strobe at the aux rate
  localparam int AUX_CW = $clog2(AUX_CYCLES + 1);
  logic [AUX_CW-1:0] aux_cnt;
  wire aux_wrap = (aux_cnt == AUX_CW'(AUX_CYCLES - 1));

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      aux_cnt <= '0;
    else
      aux_cnt <= aux_wrap ? '0 : aux_cnt + AUX_CW'(1);
  end

  // aux channels only in aux modes
  assign aux_strobe = aux_wrap && rt.aux_mode;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      aux_channel <= 3'h0;
    else if (code_load)
      aux_channel <= 3'h0;
    else if (aux_strobe)
      aux_channel <= aux_channel + 3'h1;
  end

  // top ten bits leave two bits of headroom
  wire [VID_W-1:0] samp0 = sha_samples[0*ADC_W + HEADROOM_W +: VID_W];
  wire [VID_W-1:0] samp1 = sha_samples[1*ADC_W + HEADROOM_W +: VID_W];
  wire [VID_W-1:0] samp2 = sha_samples[2*ADC_W + HEADROOM_W +: VID_W];
  wire [VID_W-1:0] samp_primary = (rt.sha_primary == SHA_2) ? samp2 :
                                  (rt.sha_primary == SHA_1) ? samp1 : samp0;

  // Stream phase: Y/C alternates Y,C; component runs Cb,Y,Cr,Y
  logic [1:0] phase;
  wire yc_chroma = (rt.fmt == FMT_YC) && phase[0];
  wire yuv_cr = (rt.fmt == FMT_YUV) && (phase == 2'h2);
  wire yuv_cb = (rt.fmt == FMT_YUV) && (phase == 2'h0);
  wire yuv_y = (rt.fmt == FMT_YUV) && phase[0];
  wire [VID_W-1:0] next_video = (yc_chroma || yuv_cb) ? samp1 :
                                yuv_cr ? samp2 :
                                (yuv_y || rt.fmt == FMT_YC) ? samp0 : samp_primary;
  // sync marks Cr or C samples only
  wire next_sync = yc_chroma || yuv_cr;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      phase <= 2'h0;
    else if (code_load)
      phase <= 2'h0;
    else if (vid_tick)
      phase <= phase + 2'h1;
  end

  // sample presented on the clock edge
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      video_out <= '0;
    else if (vid_tick)
      video_out <= next_video;
  end

  // Sync is dropped on a code change so it never outlives its format
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      sync_out <= 1'b0;
    else if (code_load)
      sync_out <= 1'b0;
    else if (vid_tick)
      sync_out <= next_sync;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      video_strobe <= 1'b0;
    else
      video_strobe <= vid_tick;
  end

  // DAC clock 1 rising edge latches, clock 0 marks DAC0
  logic dclk1_q;
  wire dclk1_rise = dclk_s[1] && !dclk1_q;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      dclk1_q <= 1'b0;
    else
      dclk1_q <= dclk_s[1];
  end

  vis_dac_latch u_dac (
    .mclk(mclk),
    .resetn(resetn),
    .latch_rise(dclk1_rise),
    .first_marker(dclk_s[0]),
    .dac_data(ddata_s),
    .dac_words(dac_words)
  );

  // overlay onto the first three DACs, only while enabled
  wire [2:0] next_ovl_route = ovl_en_s ? 3'h7 : 3'h0;
  wire [2:0] next_ovl_level = ovl_en_s ? ovl_s : 3'h0;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      overlay_route <= 3'h0;
      overlay_level <= 3'h0;
    end
    else
    begin
      overlay_route <= next_ovl_route;
      overlay_level <= next_ovl_level;
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  localparam int AUX_LAST = AUX_CYCLES - 1;
  logic [AUX_CW-1:0] aux_gap;
  logic aux_seen;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      aux_gap <= '0;
      aux_seen <= 1'b0;
    end
    else
    begin
      aux_gap <= aux_wrap ? '0 : aux_gap + AUX_CW'(1);
      aux_seen <= aux_seen || aux_wrap;
    end
  end

  property p_no_reserved;
    cur_code != SEL_RESERVED && cur_code <= SEL_AUX_IN2;
  endproperty
  a_no_reserved: assert property (p_no_reserved) else $error("Illegal code held");
  property p_sync_fmt;
    sync_out |-> (rt.fmt == FMT_YC || rt.fmt == FMT_YUV);
  endproperty
  a_sync_fmt: assert property (p_sync_fmt) else $error("Sync outside Y/C or YUV");

  property p_sync_cr;
    vid_tick && !code_load && rt.fmt == FMT_YUV && phase == 2'h2
      |=> sync_out && video_out == $past(samp2);
  endproperty
  a_sync_cr: assert property (p_sync_cr) else $error("Cr sample not marked");
  property p_yc_luma;
    vid_tick && !code_load && rt.fmt == FMT_YC && !phase[0]
      |=> !sync_out && video_out == $past(samp0);
  endproperty
  a_yc_luma: assert property (p_yc_luma) else $error("Luma sample marked");

  property p_vid_spacing;
    vid_tick |=> !vid_tick ##1 !vid_tick ##1 vid_tick;
  endproperty
  a_vid_spacing: assert property (p_vid_spacing) else $error("Video tick spacing wrong");

  property p_aux_spacing;
    aux_wrap && aux_seen |-> aux_gap == AUX_CW'(AUX_LAST);
  endproperty
  a_aux_spacing: assert property (p_aux_spacing) else $error("Aux rate wrong");
  property p_aux_chan;
    aux_strobe && !code_load |=> aux_channel == $past(aux_channel) + 3'h1;
  endproperty
  a_aux_chan: assert property (p_aux_chan) else $error("Aux channel not stepped");

  property p_single_ended;
    (single_ended != 6'h00) == aux_mode;
  endproperty
  a_single_ended: assert property (p_single_ended) else $error("Input mode mismatch");

  property p_overlay_off;
    !ovl_en_s |=> overlay_route == 3'h0 && overlay_level == 3'h0;
  endproperty
  a_overlay_off: assert property (p_overlay_off) else $error("Overlay while disabled");
  property p_yuv_sha;
    rt.fmt == FMT_YUV |-> sha_enable == 3'h7 && cdiff2_route == 6'h20;
  endproperty
  a_yuv_sha: assert property (p_yuv_sha) else $error("Component routing wrong");

  c_yc_sync: cover property (rt.fmt == FMT_YC && sync_out);
  c_yuv_sync: cover property (rt.fmt == FMT_YUV && sync_out);
  c_aux_step: cover property (aux_strobe && aux_channel == 3'h7);
  c_overlay: cover property (overlay_route == 3'h7);

endmodule

// [tb/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  import vis_pkg::*;
  localparam logic [11:0] W0 = 12'h404;
  localparam logic [11:0] W1 = 12'h808;
  localparam logic [11:0] W2 = 12'hc0c;
  localparam logic [5:0] COMP [11] = '{6'h01, 6'h02, 6'h04, 6'h00, 6'h10, 6'h20,
    6'h00, 6'h00, 6'h00, 6'h01, 6'h02};
  localparam logic [2:0] SHA [11] = '{3'h1, 3'h1, 3'h2, 3'h0, 3'h1, 3'h4, 3'h3, 3'h3,
    3'h7, 3'h1, 3'h1};
  logic mclk, resetn, overlay_enable, select_reserved, aux_mode, aux_strobe;
  logic video_strobe, sync_out, got_sync;
  logic [3:0] input_select, active_select;
  logic [35:0] sha_samples;
  logic [2:0] overlay_in, sha_enable, aux_channel, overlay_route, overlay_level;
  logic [1:0] dac_in_clocks;
  logic [9:0] dac_data, video_out, got_value;
  logic [5:0] composite_route, luma_route, chroma_route, cdiff2_route, single_ended;
  logic [39:0] dac_words;
  int err_count, samples_checked, got_count, min_gap;

  vis_top vis_top_i (.mclk(mclk), .resetn(resetn), .input_select(input_select),
    .sha_samples(sha_samples), .overlay_enable(overlay_enable),
    .overlay_in(overlay_in), .dac_in_clocks(dac_in_clocks), .dac_data(dac_data),
    .active_select(active_select), .select_reserved(select_reserved),
    .composite_route(composite_route), .luma_route(luma_route),
    .chroma_route(chroma_route), .cdiff2_route(cdiff2_route),
    .single_ended(single_ended), .sha_enable(sha_enable), .aux_mode(aux_mode),
    .aux_strobe(aux_strobe), .aux_channel(aux_channel), .video_out(video_out),
    .video_strobe(video_strobe), .sync_out(sync_out), .dac_words(dac_words),
    .overlay_route(overlay_route), .overlay_level(overlay_level));

  vis_video_sink vis_video_sink_i (.mclk(mclk), .resetn(resetn),
    .video_out(video_out), .video_strobe(video_strobe), .sync_out(sync_out),
    .got_value(got_value), .got_sync(got_sync), .got_count(got_count),
    .min_gap(min_gap));

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Two sync stages plus the hold register
  task automatic set_code(input logic [3:0] c);
    @(posedge mclk);
    input_select <= c;
    tick(4);
  endtask

  task automatic t_reset_values();
    check(active_select, SEL_RESET);
    check(sync_out, 1'b0);
    check(composite_route, 6'h01);
  endtask

  task automatic t_routes();
    for (int c = 0; c < 11; c++)
    begin
      if (c == 3)
        continue;
      set_code(c[3:0]);
      check(active_select, c);
      check(sha_enable, SHA[c]);
      check(aux_mode, c >= 9);
      check(single_ended, (c >= 9) ? 6'h3c : 6'h00);
      if (c < 6 || c > 8)
        check(composite_route, COMP[c]);
      if (c == 6)
        check({luma_route, chroma_route}, {6'h01, 6'h08});
      if (c == 7)
        check({luma_route, chroma_route}, {6'h02, 6'h04});
      if (c == 8)
        check({luma_route, chroma_route, cdiff2_route}, {6'h02, 6'h04, 6'h20});
    end
    // Reserved and out-of-range codes leave the held selection alone
    set_code(SEL_RESERVED);
    check({active_select, select_reserved}, {SEL_AUX_IN2, 1'b1});
    set_code(4'hc);
    check({active_select, select_reserved}, {SEL_AUX_IN2, 1'b1});
    set_code(SEL_CVBS_IN1);
    check(select_reserved, 1'b0);
  endtask

  // Four samples: sw must show up nsw times, carrying sync when sy is set
  task automatic t_stream(input logic [3:0] c, input logic [11:0] sw, input int nsw,
    input logic sy);
    int seen_sw;
    int n;
    seen_sw = 0;
    set_code(c);
    for (int i = 0; i < 4; i++)
    begin
      n = got_count;
      for (int k = 0; k < 20 && got_count == n; k++)
        tick(1);
      check(got_count != n, 1'b1);
      if (got_value === sw[11:2])
        seen_sw++;
      check(got_sync, sy && (got_value === sw[11:2]));
    end
    check(seen_sw, nsw);
  endtask

  task automatic t_aux();
    int gap;
    set_code(SEL_AUX_IN1);
    for (int i = 0; i < 9; i++)
    begin
      gap = 0;
      do
      begin
        tick(1);
        gap++;
      end
      while (aux_strobe !== 1'b1 && gap < 400);
      check(aux_channel, i % AUX_N);
      if (i > 0)
        check(gap, AUX_DIV);
    end
    set_code(SEL_CVBS_IN2);
    gap = 0;
    for (int k = 0; k < 300; k++)
    begin
      tick(1);
      if (aux_strobe === 1'b1)
        gap++;
    end
    check(gap, 0);
  endtask

  task automatic t_overlay();
    @(posedge mclk);
    overlay_in <= 3'h5;
    overlay_enable <= 1'b1;
    tick(4);
    check({overlay_route, overlay_level}, {3'h7, 3'h5});
    @(posedge mclk);
    overlay_enable <= 1'b0;
    tick(4);
    check(overlay_route, 3'h0);
  endtask

  // One step on the DAC pins, driven on an edge and held four cycles
  task automatic drive_dac(input logic [9:0] d, input logic [1:0] k);
    @(posedge mclk);
    dac_data <= d;
    dac_in_clocks <= k;
    tick(4);
  endtask

  // Marker on the first word sends it to DAC0, the rest follow in turn
  task automatic t_dac();
    logic [9:0] w [4] = '{10'h3a1, 10'h152, 10'h2c3, 10'h0f4};
    for (int i = 0; i < 4; i++)
    begin
      drive_dac(w[i], {1'b0, i == 0});
      drive_dac(w[i], {1'b1, i == 0});
      drive_dac(~w[i], 2'h0);
    end
    check(dac_words, {w[3], w[2], w[1], w[0]});
  endtask

  task automatic t_mid_reset();
    set_code(SEL_YUV);
    @(posedge mclk);
    resetn <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      tick(1);
      check({active_select, sync_out}, {SEL_RESET, 1'b0});
    end
    @(posedge mclk);
    resetn <= 1'b1;
    input_select <= SEL_RESET;
    tick(2);
    t_reset_values();
  endtask

  initial
  begin
    resetn = 1'b0;
    input_select = SEL_RESET;
    sha_samples = {W2, W1, W0};
    overlay_enable = 1'b0;
    overlay_in = 3'h0;
    dac_in_clocks = 2'h0;
    dac_data = 10'h000;
    err_count = 0;
    samples_checked = 0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    tick(1);
    t_reset_values();
    t_routes();
    t_stream(SEL_CVBS_IN1, W0, 4, 1'b0);
    t_stream(SEL_CVBS_IN3, W1, 4, 1'b0);
    t_stream(SEL_CVBS_IN6, W2, 4, 1'b0);
    t_stream(SEL_YC_IN2_IN3, W1, 2, 1'b1);
    t_stream(SEL_YUV, W2, 1, 1'b1);
    check(min_gap >= VID_DIV, 1'b1);
    t_aux();
    t_overlay();
    t_dac();
    t_mid_reset();
    report_and_stop();
  end

  // Whole run is about two thousand cycles; this allows 50000 cycles, over twenty times that
  initial
  begin
    #400000;
    err_count++;
    report_and_stop();
  end
endmodule

// [tb/vis_video_sink.sv]
`timescale 1ns/100ps
module vis_video_sink
  import vis_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Sample bus from the device
  input wire logic [9:0] video_out,
  input wire logic video_strobe,
  input wire logic sync_out,
  // Capture for the bench
  output logic [9:0] got_value,
  output logic got_sync,
  output int got_count,
  output int min_gap
);
  int gap;

  // take sample and sync on the rising edge
  // track the tightest strobe spacing; rate cap means at least VID_DIV
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      got_value <= '0;
      got_sync <= 1'b0;
      got_count <= 0;
      gap <= 100;
      min_gap <= 100;
    end
    else if (video_strobe === 1'b1)
    begin
      got_value <= video_out;
      got_sync <= sync_out;
      got_count <= got_count + 1;
      gap <= 1;
      if (gap < min_gap)
        min_gap <= gap;
    end
    else
      gap <= gap + 1;
endmodule
